// ===== rtl/bsu_map.vh
// Constants for the branch, skip and bit unit: operation codes, status bit
// positions, cycle counts and the software register map.
// Assumes an outside decoder that turns instruction words into an operation
// code plus operand fields, and a core that stalls fetch while busy is high.
`ifndef BSU_MAP_VH
`define BSU_MAP_VH

// Operation codes presented by the decoder.
`define BSU_OP_NONE        5'h00
`define BSU_OP_PTR_JUMP    5'h01
`define BSU_OP_PTR_CALL    5'h02
`define BSU_OP_REL_JUMP    5'h03
`define BSU_OP_REL_CALL    5'h04
`define BSU_OP_RETURN      5'h05
`define BSU_OP_INT_RETURN  5'h06
`define BSU_OP_CMP_SKIP_EQ 5'h07
`define BSU_OP_CMP         5'h08
`define BSU_OP_CMP_CARRY   5'h09
`define BSU_OP_CMP_IMM     5'h0a
`define BSU_OP_SKIP_RB_CLR 5'h0b
`define BSU_OP_SKIP_RB_SET 5'h0c
`define BSU_OP_SKIP_IO_CLR 5'h0d
`define BSU_OP_SKIP_IO_SET 5'h0e
`define BSU_OP_BR_FLAG_SET 5'h0f
`define BSU_OP_BR_FLAG_CLR 5'h10
`define BSU_OP_IO_BIT_SET  5'h11
`define BSU_OP_IO_BIT_CLR  5'h12

// Status flags register bit positions.
`define BSU_FLAG_C 3'h0
`define BSU_FLAG_Z 3'h1
`define BSU_FLAG_N 3'h2
`define BSU_FLAG_V 3'h3
`define BSU_FLAG_S 3'h4
`define BSU_FLAG_H 3'h5
`define BSU_FLAG_T 3'h6
`define BSU_FLAG_I 3'h7

// Cycle counts per instruction.
`define BSU_CYC_ONE        3'h1
`define BSU_CYC_TWO        3'h2
`define BSU_CYC_THREE      3'h3
`define BSU_CYC_FOUR       3'h4

// Software register map and reset values.
`define BSU_REG_CTRL       8'h00
`define BSU_REG_STATUS     8'h04
`define BSU_REG_RETIRED    8'h08
`define BSU_REG_LAST_PC    8'h0c
`define BSU_CTRL_ENABLE    0
`define BSU_CTRL_CLR_CNT   1
`define BSU_CTRL_RESET     2'h1

`endif

// ===== rtl/bsu_unit.v
// Branch, skip and bit-instruction execution unit of an 8-bit core.
// Assumes a decoder that presents one operation per accepted cycle with its
// operands, a register file and I/O space read combinationally in the same
// cycle, and a stack that returns popped data one cycle after a pop request.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "bsu_map.vh"

module bsu_unit
(
  input  wire        clk,          // Core clock, 200 MHz.
  input  wire        reset_n,      // Asynchronous reset, active low.
  input  wire        op_valid,     // Decoder presents an operation.
  input  wire [4:0]  op_code,      // Operation code.
  input  wire [2:0]  op_bit,       // Bit or flag select.
  input  wire [11:0] op_offset,    // Signed relative offset in words.
  input  wire [4:0]  op_io_addr,   // Low I/O register address.
  input  wire        next_is_long, // Following instruction is two words.
  input  wire [15:0] pc_cur,       // Address of the presented instruction.
  input  wire [15:0] z_pointer,    // Z pointer pair.
  input  wire [7:0]  rd_data,      // First operand register.
  input  wire [7:0]  rr_data,      // Second operand or immediate.
  input  wire [7:0]  status_in,    // Current status flags register.
  input  wire [7:0]  io_rdata,     // Data of the addressed I/O register.
  input  wire [15:0] pop_data,     // Stack data, one cycle after pop.
  output wire        op_ready,     // Unit can take an operation.
  output reg         pc_load_ff,   // One-cycle pulse: load program counter.
  output reg  [15:0] pc_target_ff, // New program counter value.
  output reg         flags_we_ff,  // One-cycle pulse: write status flags.
  output reg  [7:0]  flags_out_ff, // New status flags value.
  output reg         push_ff,      // One-cycle pulse: push return address.
  output reg  [15:0] push_data_ff, // Return address to push.
  output reg         pop_ff,       // One-cycle pulse: pop return address.
  output reg         io_we_ff,     // One-cycle pulse: write I/O register.
  output reg  [4:0]  io_waddr_ff,  // I/O register write address.
  output reg  [7:0]  io_wdata_ff,  // I/O register write data.
  input  wire [7:0]  sw_addr,      // Software register address.
  input  wire [31:0] sw_wdata,     // Software write data.
  input  wire        sw_wr,        // Software write strobe.
  input  wire        sw_rd,        // Software read strobe.
  output reg  [31:0] sw_rdata_ff   // Software read data, one cycle later.
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [2:0]  cnt_ff;
  reg  [4:0]  op_ff;
  reg  [15:0] target_ff;
  reg  [7:0]  io_data_ff;
  reg  [2:0]  bit_ff;
  reg  [4:0]  io_addr_ff;
  reg         taken_ff;
  reg  [1:0]  ctrl_ff;
  reg  [15:0] retired_ff;
  reg  [15:0] last_pc_ff;

  reg  [2:0]  nxt_cycles;
  reg  [15:0] nxt_target;
  reg         nxt_taken;
  reg         flag_sel;
  reg         cmp_op;

  wire        accept;
  wire        finish;
  wire [15:0] rel_target;
  wire [15:0] skip_target;
  wire        carry_in;
  wire [8:0]  cmp_diff;
  wire [4:0]  cmp_low;
  wire [7:0]  cmp_flags;
  wire        cmp_v;

  // The unit stalls fetch while a multi-cycle operation runs; software can
  // park it by clearing the enable bit, which also stalls the core.
  assign op_ready = state_ff[0] & ctrl_ff[`BSU_CTRL_ENABLE];
  assign accept   = op_valid & op_ready;
  assign finish   = state_ff[1] & (cnt_ff == `BSU_CYC_ONE);

  // Relative targets: offset plus one word past the current instruction.
  assign rel_target  = pc_cur + {{4{op_offset[11]}}, op_offset} + 16'h0001;
  assign skip_target = pc_cur + (next_is_long ? 16'h0003 : 16'h0002);

  // Compare arithmetic; only the carry variant subtracts the incoming carry.
  assign carry_in = (op_code == `BSU_OP_CMP_CARRY) & status_in[`BSU_FLAG_C];
  assign cmp_diff = {1'b0, rd_data} - {1'b0, rr_data} - {8'h00, carry_in};
  assign cmp_low  = {1'b0, rd_data[3:0]} - {1'b0, rr_data[3:0]} - {4'h0, carry_in};
  assign cmp_v    = (rd_data[7] & ~rr_data[7] & ~cmp_diff[7]) |
                    (~rd_data[7] & rr_data[7] & cmp_diff[7]);

  // Zero from the carry variant keeps a previous zero clear, so multi-byte
  // compares chain correctly; S, T and I pass through untouched.
  assign cmp_flags[`BSU_FLAG_C] = cmp_diff[8];
  assign cmp_flags[`BSU_FLAG_Z] = (cmp_diff[7:0] == 8'h00) &
                                  ((op_code != `BSU_OP_CMP_CARRY) | status_in[`BSU_FLAG_Z]);
  assign cmp_flags[`BSU_FLAG_N] = cmp_diff[7];
  assign cmp_flags[`BSU_FLAG_V] = cmp_v;
  assign cmp_flags[`BSU_FLAG_S] = status_in[`BSU_FLAG_S];
  assign cmp_flags[`BSU_FLAG_H] = cmp_low[4];
  assign cmp_flags[`BSU_FLAG_T] = status_in[`BSU_FLAG_T];
  assign cmp_flags[`BSU_FLAG_I] = status_in[`BSU_FLAG_I];

  // Status bit selected by a conditional branch; the signed-test position is
  // formed from negative XOR overflow so it never depends on a stale bit.
  always @*
  begin
    case (op_bit)
      `BSU_FLAG_C: flag_sel = status_in[`BSU_FLAG_C];
      `BSU_FLAG_Z: flag_sel = status_in[`BSU_FLAG_Z];
      `BSU_FLAG_N: flag_sel = status_in[`BSU_FLAG_N];
      `BSU_FLAG_V: flag_sel = status_in[`BSU_FLAG_V];
      `BSU_FLAG_S: flag_sel = status_in[`BSU_FLAG_N] ^ status_in[`BSU_FLAG_V];
      `BSU_FLAG_H: flag_sel = status_in[`BSU_FLAG_H];
      `BSU_FLAG_T: flag_sel = status_in[`BSU_FLAG_T];
      `BSU_FLAG_I: flag_sel = status_in[`BSU_FLAG_I];
      default:     flag_sel = 1'b0;
    endcase
  end

  // Decode: cycle count, whether the program counter is reloaded, and where.
  always @*
  begin
    nxt_cycles = `BSU_CYC_ONE;
    nxt_target = skip_target;
    nxt_taken  = 1'b0;
    cmp_op     = 1'b0;
    case (op_code)
      `BSU_OP_PTR_JUMP:
      begin
        nxt_cycles = `BSU_CYC_TWO;
        nxt_target = z_pointer;
        nxt_taken  = 1'b1;
      end
      `BSU_OP_PTR_CALL:
      begin
        nxt_cycles = `BSU_CYC_THREE;
        nxt_target = z_pointer;
        nxt_taken  = 1'b1;
      end
      `BSU_OP_REL_JUMP:
      begin
        nxt_cycles = `BSU_CYC_TWO;
        nxt_target = rel_target;
        nxt_taken  = 1'b1;
      end
      `BSU_OP_REL_CALL:
      begin
        nxt_cycles = `BSU_CYC_THREE;
        nxt_target = rel_target;
        nxt_taken  = 1'b1;
      end
      `BSU_OP_RETURN, `BSU_OP_INT_RETURN:
      begin
        nxt_cycles = `BSU_CYC_FOUR;
        nxt_taken  = 1'b1;
      end
      `BSU_OP_CMP_SKIP_EQ:
        nxt_taken = (rd_data == rr_data);
      `BSU_OP_CMP, `BSU_OP_CMP_CARRY, `BSU_OP_CMP_IMM:
        cmp_op = 1'b1;
      `BSU_OP_SKIP_RB_CLR:
        nxt_taken = ~rd_data[op_bit];
      `BSU_OP_SKIP_RB_SET:
        nxt_taken = rd_data[op_bit];
      `BSU_OP_SKIP_IO_CLR:
        nxt_taken = ~io_rdata[op_bit];
      `BSU_OP_SKIP_IO_SET:
        nxt_taken = io_rdata[op_bit];
      `BSU_OP_BR_FLAG_SET:
      begin
        nxt_taken  = flag_sel;
        nxt_target = rel_target;
      end
      `BSU_OP_BR_FLAG_CLR:
      begin
        nxt_taken  = ~flag_sel;
        nxt_target = rel_target;
      end
      `BSU_OP_IO_BIT_SET, `BSU_OP_IO_BIT_CLR:
        nxt_cycles = `BSU_CYC_TWO;
      default:
        nxt_cycles = `BSU_CYC_ONE;
    endcase
    // A taken skip costs one extra cycle per word jumped over; a taken
    // conditional branch costs one extra cycle.
    if (nxt_taken && (op_code >= `BSU_OP_CMP_SKIP_EQ) &&
        (op_code <= `BSU_OP_SKIP_IO_SET))
      nxt_cycles = next_is_long ? `BSU_CYC_THREE : `BSU_CYC_TWO;
    else if (nxt_taken && ((op_code == `BSU_OP_BR_FLAG_SET) ||
             (op_code == `BSU_OP_BR_FLAG_CLR)))
      nxt_cycles = `BSU_CYC_TWO;
  end

  // State sequencing: single-cycle work finishes in the accept cycle.
  always @*
  begin
    case (state_ff)
      ST_IDLE: nxt_state = (accept && (nxt_cycles != `BSU_CYC_ONE)) ? ST_WAIT : ST_IDLE;
      ST_WAIT: nxt_state = finish ? ST_IDLE : ST_WAIT;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Operation context held for the cycles that follow acceptance.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 3'h0;
      op_ff      <= `BSU_OP_NONE;
      target_ff  <= 16'h0000;
      io_data_ff <= 8'h00;
      bit_ff     <= 3'h0;
      io_addr_ff <= 5'h00;
      taken_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (accept)
      begin
        cnt_ff     <= nxt_cycles - 3'h1;
        op_ff      <= op_code;
        target_ff  <= nxt_target;
        io_data_ff <= io_rdata;
        bit_ff     <= op_bit;
        io_addr_ff <= op_io_addr;
        taken_ff   <= nxt_taken;
      end
      else if (state_ff[1])
      begin
        cnt_ff <= cnt_ff - 3'h1;
        // Stack answers one cycle after the pop pulse, in cycle two.
        if (((op_ff == `BSU_OP_RETURN) || (op_ff == `BSU_OP_INT_RETURN)) &&
            (cnt_ff == `BSU_CYC_TWO))
          target_ff <= pop_data;
      end
    end
  end

  // Side effects. Flags are only written by compares and interrupt return,
  // so every other operation leaves the status register alone.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_load_ff   <= 1'b0;
      pc_target_ff <= 16'h0000;
      flags_we_ff  <= 1'b0;
      flags_out_ff <= 8'h00;
      push_ff      <= 1'b0;
      push_data_ff <= 16'h0000;
      pop_ff       <= 1'b0;
      io_we_ff     <= 1'b0;
      io_waddr_ff  <= 5'h00;
      io_wdata_ff  <= 8'h00;
    end
    else
    begin
      pc_load_ff  <= 1'b0;
      flags_we_ff <= 1'b0;
      push_ff     <= 1'b0;
      pop_ff      <= 1'b0;
      io_we_ff    <= 1'b0;
      if (accept)
      begin
        if (cmp_op)
        begin
          flags_we_ff  <= 1'b1;
          flags_out_ff <= cmp_flags;
        end
        if ((op_code == `BSU_OP_PTR_CALL) || (op_code == `BSU_OP_REL_CALL))
        begin
          push_ff      <= 1'b1;
          push_data_ff <= pc_cur + 16'h0001;
        end
        if ((op_code == `BSU_OP_RETURN) || (op_code == `BSU_OP_INT_RETURN))
          pop_ff <= 1'b1;
        // Multi-cycle work from a taken skip or branch reloads at once.
        if ((nxt_cycles != `BSU_CYC_ONE) && nxt_taken &&
            (op_code >= `BSU_OP_CMP_SKIP_EQ) && (op_code <= `BSU_OP_BR_FLAG_CLR))
        begin
          pc_load_ff   <= 1'b1;
          pc_target_ff <= nxt_target;
        end
      end
      else if (finish)
      begin
        if ((op_ff <= `BSU_OP_INT_RETURN) && taken_ff)
        begin
          pc_load_ff   <= 1'b1;
          pc_target_ff <= target_ff;
        end
        if (op_ff == `BSU_OP_INT_RETURN)
        begin
          flags_we_ff  <= 1'b1;
          flags_out_ff <= status_in | (8'h01 << `BSU_FLAG_I);
        end
        // Only the addressed bit changes; the others are written back as read.
        if ((op_ff == `BSU_OP_IO_BIT_SET) || (op_ff == `BSU_OP_IO_BIT_CLR))
        begin
          io_we_ff    <= 1'b1;
          io_waddr_ff <= io_addr_ff;
          io_wdata_ff <= (op_ff == `BSU_OP_IO_BIT_SET) ?
                         (io_data_ff | (8'h01 << bit_ff)) :
                         (io_data_ff & ~(8'h01 << bit_ff));
        end
      end
    end
  end

  // Software registers: control, live status, retired count and last target.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_ff     <= `BSU_CTRL_RESET;
      retired_ff  <= 16'h0000;
      last_pc_ff  <= 16'h0000;
      sw_rdata_ff <= 32'h00000000;
    end
    else
    begin
      if (sw_wr && (sw_addr == `BSU_REG_CTRL))
        ctrl_ff <= sw_wdata[1:0];
      // Clearing takes priority over counting in the same cycle.
      if (ctrl_ff[`BSU_CTRL_CLR_CNT])
        retired_ff <= 16'h0000;
      else if ((accept && (nxt_cycles == `BSU_CYC_ONE)) || finish)
        retired_ff <= retired_ff + 16'h0001;
      if (pc_load_ff)
        last_pc_ff <= pc_target_ff;
      sw_rdata_ff <= 32'h00000000;
      if (sw_rd)
      begin
        case (sw_addr)
          `BSU_REG_CTRL:    sw_rdata_ff <= {30'h00000000, ctrl_ff};
          `BSU_REG_STATUS:  sw_rdata_ff <= {30'h00000000, taken_ff, state_ff[1]};
          `BSU_REG_RETIRED: sw_rdata_ff <= {16'h0000, retired_ff};
          `BSU_REG_LAST_PC: sw_rdata_ff <= {16'h0000, last_pc_ff};
          default:          sw_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== bench/bsu_check_sva.sv
// Checker for the branch, skip and bit unit: control-flow timing and targets.
// Assumes it is bound to bsu_unit and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "bsu_map.vh"

module bsu_check
(
  input wire logic        clk,          // Core clock.
  input wire logic        reset_n,      // Asynchronous reset, active low.
  input wire logic        op_valid,     // Operation presented.
  input wire logic [4:0]  op_code,      // Operation code.
  input wire logic [2:0]  op_bit,       // Bit or flag select.
  input wire logic [11:0] op_offset,    // Signed word offset.
  input wire logic [4:0]  op_io_addr,   // I/O address.
  input wire logic        next_is_long, // Next instruction is two words.
  input wire logic [15:0] pc_cur,       // Current instruction address.
  input wire logic [15:0] z_pointer,    // Pointer pair.
  input wire logic [7:0]  rd_data,      // First operand.
  input wire logic [7:0]  status_in,    // Status flags.
  input wire logic [7:0]  io_rdata,     // I/O read data.
  input wire logic [15:0] pop_data,     // Stack data.
  input wire logic        op_ready,     // Unit idle and enabled.
  input wire logic        pc_load_ff,   // Load pulse.
  input wire logic [15:0] pc_target_ff, // Load target.
  input wire logic        flags_we_ff,  // Flag write pulse.
  input wire logic        push_ff,      // Push pulse.
  input wire logic [15:0] push_data_ff, // Pushed address.
  input wire logic        pop_ff,       // Pop pulse.
  input wire logic        io_we_ff,     // I/O write pulse.
  input wire logic [4:0]  io_waddr_ff,  // I/O write address.
  input wire logic [7:0]  io_wdata_ff   // I/O write data.
);
  // An operation counts only on an edge where the unit was ready for it.
  wire        acc = op_valid && op_ready;
  wire [15:0] rel = pc_cur + {{4{op_offset[11]}}, op_offset} + 16'h0001;
  wire        nv  = op_bit != 3'h4;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  cmp_flags_a: assert property (acc && op_code == `BSU_OP_CMP |=> flags_we_ff && !io_we_ff && !pc_load_ff)
    else $error("compare did not write flags alone");
  ptr_jump_a: assert property (acc && op_code == `BSU_OP_PTR_JUMP |=> !pc_load_ff && !flags_we_ff ##1 pc_load_ff && pc_target_ff == $past(z_pointer, 2))
    else $error("pointer jump target or timing wrong");
  ptr_call_a: assert property (acc && op_code == `BSU_OP_PTR_CALL |=> push_ff && push_data_ff == $past(pc_cur) + 16'h0001 ##2 pc_load_ff && pc_target_ff == $past(z_pointer, 3))
    else $error("pointer call push or load wrong");
  br_set_a: assert property (acc && op_code == `BSU_OP_BR_FLAG_SET && nv && status_in[op_bit] |=> pc_load_ff && pc_target_ff == $past(rel))
    else $error("taken flag-set branch wrong");
  br_clr_a: assert property (acc && op_code == `BSU_OP_BR_FLAG_CLR && nv && !status_in[op_bit] |=> pc_load_ff && pc_target_ff == $past(rel))
    else $error("taken flag-clear branch wrong");
  br_not_a: assert property (acc && op_code == `BSU_OP_BR_FLAG_SET && nv && !status_in[op_bit] |=> !pc_load_ff && op_ready)
    else $error("untaken branch loaded or stalled");
  skip_bit_a: assert property (acc && op_code == `BSU_OP_SKIP_RB_SET && rd_data[op_bit] |=> pc_load_ff && pc_target_ff == $past(pc_cur) + ($past(next_is_long) ? 16'h0003 : 16'h0002))
    else $error("register bit skip target wrong");
  io_set_a: assert property (acc && op_code == `BSU_OP_IO_BIT_SET |=> !io_we_ff ##1 io_we_ff && io_waddr_ff == $past(op_io_addr, 2) && io_wdata_ff == ($past(io_rdata, 2) | (8'h01 << $past(op_bit, 2))))
    else $error("io bit set write wrong");
  call_busy_a: assert property (acc && op_code == `BSU_OP_REL_CALL |=> !op_ready [*2])
    else $error("relative call not busy two cycles");
  ret_pop_a: assert property (acc && op_code == `BSU_OP_RETURN |=> pop_ff ##3 pc_load_ff && pc_target_ff == $past(pop_data, 2))
    else $error("return pop or load wrong");

  // Main scenarios worth seeing at least once.
  cov_branch_c: cover property (acc && op_code == `BSU_OP_BR_FLAG_SET ##1 pc_load_ff);
  cov_call_c: cover property (acc && op_code == `BSU_OP_PTR_CALL ##1 push_ff);
  cov_io_c: cover property (acc && op_code == `BSU_OP_IO_BIT_CLR ##2 io_we_ff);
endmodule

bind bsu_unit bsu_check u_chk (.clk, .reset_n, .op_valid, .op_code, .op_bit, .op_offset,
  .op_io_addr, .next_is_long, .pc_cur, .z_pointer, .rd_data, .status_in, .io_rdata,
  .pop_data, .op_ready, .pc_load_ff, .pc_target_ff, .flags_we_ff, .push_ff, .push_data_ff,
  .pop_ff, .io_we_ff, .io_waddr_ff, .io_wdata_ff);
`default_nettype wire

// ===== bench/bsu_unit_test.sv
// Self-checking bench for the branch, skip and bit unit.
// Assumes bsu_unit and bsu_map.vh; the bench plays decoder, register file and stack.
`timescale 1ns/100ps
`default_nettype none
`include "bsu_map.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module branch_skip_bit_instruction_unit_test;
  logic        clk, reset_n, op_valid, next_is_long, sw_wr, sw_rd;
  logic [4:0]  op_code, op_io_addr;
  logic [2:0]  op_bit;
  logic [11:0] op_offset;
  logic [15:0] pc_cur, z_pointer, pop_data, ld_t, ps_d;
  logic [7:0]  rd_data, rr_data, status_in, io_rdata, sw_addr, fl_d, iw_d;
  logic [31:0] sw_wdata;
  logic [4:0]  iw_a;
  wire logic        op_ready, pc_load_ff, flags_we_ff, push_ff, pop_ff, io_we_ff;
  wire logic [15:0] pc_target_ff, push_data_ff;
  wire logic [7:0]  flags_out_ff, io_wdata_ff;
  wire logic [4:0]  io_waddr_ff;
  wire logic [31:0] sw_rdata_ff;
  integer failures, checks_done, cyc, ld_c, rdy_c, fw_c, iw_c, psh_c;

  bsu_unit uut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
    .op_bit(op_bit), .op_offset(op_offset), .op_io_addr(op_io_addr),
    .next_is_long(next_is_long), .pc_cur(pc_cur), .z_pointer(z_pointer), .rd_data(rd_data),
    .rr_data(rr_data), .status_in(status_in), .io_rdata(io_rdata), .pop_data(pop_data),
    .op_ready(op_ready), .pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff),
    .flags_we_ff(flags_we_ff), .flags_out_ff(flags_out_ff), .push_ff(push_ff),
    .push_data_ff(push_data_ff), .pop_ff(pop_ff), .io_we_ff(io_we_ff),
    .io_waddr_ff(io_waddr_ff), .io_wdata_ff(io_wdata_ff), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_ff(sw_rdata_ff));

  // 200 MHz core clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A hang would otherwise run forever; the whole run needs far fewer cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000) begin failures++; results(); end
  end

  task automatic results();
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Presents one operation for one cycle, then records which cycle each effect lands in.
  task automatic exec(input logic [4:0] op, input logic [2:0] b, input logic [11:0] off,
                      input logic [7:0] st, rd, rr, io, input logic lg);
    integer i;
    ld_c = 0; rdy_c = 0; fw_c = 0; iw_c = 0; psh_c = 0; ld_t = 'x;
    @(posedge clk);
    op_code <= op; op_bit <= b; op_offset <= off; status_in <= st;
    rd_data <= rd; rr_data <= rr; io_rdata <= io; next_is_long <= lg; op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    // Cycle one is the one launched by the accepting edge, so look before the next edge.
    for (i = 1; i <= 5; i++)
    begin
      #1;
      if (pc_load_ff === 1'b1) begin ld_c = i; ld_t = pc_target_ff; end
      if (flags_we_ff === 1'b1) begin fw_c = i; fl_d = flags_out_ff; end
      if (io_we_ff === 1'b1) begin iw_c = i; iw_a = io_waddr_ff; iw_d = io_wdata_ff; end
      if (push_ff === 1'b1) begin psh_c = i; ps_d = push_data_ff; end
      if (op_ready === 1'b1 && rdy_c == 0) rdy_c = i;
      @(posedge clk);
    end
  endtask

  task automatic sw_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a; sw_wdata <= d; sw_wr <= wr; sw_rd <= !wr;
    @(posedge clk);
    sw_wr <= 1'b0; sw_rd <= 1'b0;
    #1;
  endtask

  // Jumps, calls and returns: cycle of the load, its target and the push.
  task automatic t_flow();
    exec(`BSU_OP_PTR_JUMP, 0, 0, 8'h00, 0, 0, 0, 0);
    `CHK("jump load", 2, ld_c) `CHK("jump pc", 16'h0abc, ld_t) `CHK("jump flags", 0, fw_c)
    exec(`BSU_OP_PTR_CALL, 0, 0, 8'h00, 0, 0, 0, 0);
    `CHK("call load", 3, ld_c) `CHK("call pc", 16'h0abc, ld_t) `CHK("call rdy", 3, rdy_c)
    `CHK("call push", 1, psh_c) `CHK("call ret", 16'h1235, ps_d) `CHK("call fl", 0, fw_c)
    exec(`BSU_OP_REL_JUMP, 0, 12'hffe, 8'h00, 0, 0, 0, 0);
    `CHK("relative_jump load", 2, ld_c) `CHK("relative_jump pc", 16'h1233, ld_t)
    exec(`BSU_OP_REL_CALL, 0, 12'h010, 8'h00, 0, 0, 0, 0);
    `CHK("relative_call load", 3, ld_c) `CHK("relative_call pc", 16'h1245, ld_t) `CHK("relative_call ret", 16'h1235, ps_d)
    exec(`BSU_OP_RETURN, 0, 0, 8'h00, 0, 0, 0, 0);
    `CHK("ret load", 4, ld_c) `CHK("ret pc", 16'h0777, ld_t) `CHK("ret fl", 0, fw_c)
    exec(`BSU_OP_INT_RETURN, 0, 0, 8'h00, 0, 0, 0, 0);
    `CHK("interrupt_return load", 4, ld_c) `CHK("interrupt_return fl", 4, fw_c) `CHK("interrupt_return i", 1'b1, fl_d[7])
  endtask

  // Compare: expected flags from the subtraction, with S, T and I carried over.
  task automatic cmp(input logic [4:0] op, input logic [7:0] a, b, st);
    logic [7:0] r, e;
    logic       c;
    c = (op == `BSU_OP_CMP_CARRY) ? st[0] : 1'b0;
    r = a - b - c;
    e = st & 8'hd0;
    e[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    e[1] = (r == 8'h00) && (op != `BSU_OP_CMP_CARRY || st[1]);
    e[2] = r[7];
    e[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    e[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    exec(op, 0, 0, st, a, b, 0, 0);
    `CHK("cmp cyc", 1, fw_c) `CHK("cmp flags", e, fl_d) `CHK("cmp rdy", 1, rdy_c)
    `CHK("cmp ld", 0, ld_c) `CHK("cmp io", 0, iw_c)
  endtask

  // Skips: taken ones load pc plus two or three and hold the unit one or two cycles.
  task automatic skip(input logic [4:0] op, input logic [7:0] rd, rr, io, input logic [2:0] b,
                      input logic lg, tk);
    exec(op, b, 0, 8'h00, rd, rr, io, lg);
    `CHK("skip ld", tk ? 1 : 0, ld_c) `CHK("skip rdy", tk ? (lg ? 3 : 2) : 1, rdy_c)
    if (tk) `CHK("skip pc", lg ? 16'h1237 : 16'h1236, ld_t)
    `CHK("skip fl", 0, fw_c)
  endtask

  // Every flag select with both branch senses over flag patterns, boundary offsets too.
  task automatic t_branch();
    logic [7:0]  m;
    logic [7:0]  s;
    logic [11:0] off;
    logic        f, tk;
    for (int b = 0; b < 8; b++)
      for (int k = 0; k < 8; k++)
      begin
        // A lone bit or a lone hole at the tested flag; the signed test uses N alone.
        m = (b == 4) ? 8'h04 : (8'h01 << b);
        s = k[1] ? (k[0] ? ~m : m) : (k[0] ? 8'hff : 8'h00);
        f = (b == 4) ? (s[2] ^ s[3]) : s[b];
        tk = k[2] ? !f : f;
        off = k[0] ? 12'h800 : 12'h7ff;
        exec(k[2] ? `BSU_OP_BR_FLAG_CLR : `BSU_OP_BR_FLAG_SET, b, off, s, 0, 0, 0, 0);
        `CHK("br ld", tk ? 1 : 0, ld_c) `CHK("br rdy", tk ? 2 : 1, rdy_c)
        if (tk) `CHK("br pc", 16'h1235 + {{4{off[11]}}, off}, ld_t)
      end
  endtask

  // Single I/O bit set and clear at the top address and both ends of the bit range.
  task automatic t_io();
    exec(`BSU_OP_IO_BIT_SET, 7, 0, 8'h00, 0, 0, 8'h00, 0);
    `CHK("sbit cyc", 2, iw_c) `CHK("sbit d", 8'h80, iw_d) `CHK("sbit fl", 0, fw_c)
    `CHK("sbit a", 5'h1f, iw_a)
    exec(`BSU_OP_IO_BIT_CLR, 0, 0, 8'h00, 0, 0, 8'hff, 0);
    `CHK("cbit cyc", 2, iw_c) `CHK("cbit d", 8'hfe, iw_d) `CHK("cbit rdy", 2, rdy_c)
  endtask

  // Software port: reset value, unmapped read, and refusal while disabled.
  task automatic t_sw();
    sw_acc(1'b0, `BSU_REG_CTRL, 0);
    `CHK("ctrl", 32'h00000001, sw_rdata_ff)
    sw_acc(1'b0, 8'h20, 0);
    `CHK("unmapped", 32'h00000000, sw_rdata_ff)
    sw_acc(1'b1, `BSU_REG_CTRL, 32'h00000000);
    `CHK("off ready", 1'b0, op_ready)
    exec(`BSU_OP_PTR_JUMP, 0, 0, 8'h00, 0, 0, 0, 0);
    `CHK("off ld", 0, ld_c)
    sw_acc(1'b1, `BSU_REG_CTRL, 32'h00000001);
    `CHK("on ready", 1'b1, op_ready)
  endtask

  // Software view after the six flow operations: count, last target, status, clearing.
  task automatic t_regs();
    sw_acc(1'b0, `BSU_REG_RETIRED, 0);
    `CHK("retired", 32'h00000006, sw_rdata_ff)
    sw_acc(1'b0, `BSU_REG_LAST_PC, 0);
    `CHK("last pc", 32'h00000777, sw_rdata_ff)
    sw_acc(1'b0, `BSU_REG_STATUS, 0);
    `CHK("status", 32'h00000002, sw_rdata_ff)
    sw_acc(1'b1, `BSU_REG_CTRL, 32'h00000003);
    sw_acc(1'b0, `BSU_REG_RETIRED, 0);
    `CHK("cleared", 32'h00000000, sw_rdata_ff)
    sw_acc(1'b1, `BSU_REG_CTRL, 32'h00000001);
  endtask

  // Main sequence: everything driven at time zero, reset for five cycles.
  initial
  begin
    failures = 0; checks_done = 0; cyc = 0;
    reset_n = 1'b0; op_valid = 1'b0; op_code = 5'h00; op_bit = 3'h0; op_offset = 12'h000;
    op_io_addr = 5'h1f; next_is_long = 1'b0; pc_cur = 16'h1234; z_pointer = 16'h0abc;
    rd_data = 8'h00; rr_data = 8'h00; status_in = 8'h00; io_rdata = 8'h00;
    pop_data = 16'h0777; sw_addr = 8'h00; sw_wdata = 32'h0; sw_wr = 1'b0; sw_rd = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_sw();
    t_flow();
    t_regs();
    cmp(`BSU_OP_CMP, 8'h10, 8'h01, 8'h00);
    cmp(`BSU_OP_CMP_CARRY, 8'h00, 8'hff, 8'h03);
    cmp(`BSU_OP_CMP_IMM, 8'h80, 8'h01, 8'he0);
    skip(`BSU_OP_CMP_SKIP_EQ, 8'h05, 8'h05, 0, 0, 1, 1);
    skip(`BSU_OP_CMP_SKIP_EQ, 8'h05, 8'h04, 0, 0, 0, 0);
    skip(`BSU_OP_SKIP_RB_CLR, 8'hfe, 0, 0, 0, 0, 1);
    skip(`BSU_OP_SKIP_RB_CLR, 8'h01, 0, 0, 0, 1, 0);
    skip(`BSU_OP_SKIP_RB_SET, 8'h80, 0, 0, 7, 1, 1);
    skip(`BSU_OP_SKIP_RB_SET, 8'h7f, 0, 0, 7, 0, 0);
    skip(`BSU_OP_SKIP_IO_CLR, 0, 0, 8'hf7, 3, 0, 1);
    skip(`BSU_OP_SKIP_IO_SET, 0, 0, 8'h08, 3, 1, 1);
    skip(`BSU_OP_SKIP_IO_SET, 0, 0, 8'hf7, 3, 0, 0);
    t_branch();
    t_io();
    results();
  end
endmodule
`default_nettype wire
